/* design/timer2_consts.svh */
// offsets, reset values and divider counts of the timer 2 capture/reload unit
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define T2_ADDR_W        12
`define T2_OFF_CONTROL   12'h000
`define T2_OFF_COUNT_LO  12'h004
`define T2_OFF_COUNT_HI  12'h008
`define T2_OFF_CAP_LO    12'h00C
`define T2_OFF_CAP_HI    12'h010

// ----------------------------------------------------------------
// reset values and count maximum
// ----------------------------------------------------------------
`define T2_CONTROL_RESET 8'h00
`define T2_BYTE_RESET    8'h00
`define T2_COUNT_MAX     16'hFFFF

// ----------------------------------------------------------------
// oscillator divide counts
// ----------------------------------------------------------------
`define T2_TIMER_DIV     12
`define T2_BAUD_DIV      2

`endif

/* design/timer2_pkg.sv */
// types shared by the timer 2 capture/reload unit
package timer2_pkg;

    typedef struct packed {
        logic overflow_flag;
        logic external_event_flag;
        logic rx_clock_select;
        logic tx_clock_select;
        logic external_trigger_enable;
        logic run_control;
        logic count_source_select;
        logic capture_or_reload_select;
    } timer2_control_t;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_RELOAD,
        MODE_CAPTURE,
        MODE_BAUD
    } t2_mode_t;

    typedef enum logic [2:0] {
        REG_CONTROL,
        REG_COUNT_LO,
        REG_COUNT_HI,
        REG_CAP_LO,
        REG_CAP_HI,
        REG_NONE
    } t2_reg_t;

endpackage

/* design/falling_edge_sync.sv */
// two-flop synchroniser with falling edge detector
`timescale 1ns/1ps
`default_nettype none

module falling_edge_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output var  logic fall
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // meta_q feeds only sync_q
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign fall = prev_q & ~sync_q;

endmodule

`default_nettype wire

/* design/timer2_capture_reload_unit.sv */
// timer 2: 16-bit timer/counter with capture, auto-reload and baud modes, apb slave
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer2_consts.svh"

module timer2_capture_reload_unit #(
    parameter int TIMER_DIV = `T2_TIMER_DIV,
    parameter int BAUD_DIV  = `T2_BAUD_DIV
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        external_count_pin,
    input  wire logic        external_trigger_pin,
    input  wire logic        timer1_overflow,
    input  wire logic        timer2_irq_enable,
    output var  logic        timer2_irq,
    output var  logic        rx_baud_tick,
    output var  logic        tx_baud_tick
);

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic timer2_pkg::t2_reg_t reg_of(input logic [11:0] a);
        timer2_pkg::t2_reg_t r;
        r = timer2_pkg::REG_NONE;
        unique case (a)
            `T2_OFF_CONTROL:  r = timer2_pkg::REG_CONTROL;
            `T2_OFF_COUNT_LO: r = timer2_pkg::REG_COUNT_LO;
            `T2_OFF_COUNT_HI: r = timer2_pkg::REG_COUNT_HI;
            `T2_OFF_CAP_LO:   r = timer2_pkg::REG_CAP_LO;
            `T2_OFF_CAP_HI:   r = timer2_pkg::REG_CAP_HI;
            default:          r = timer2_pkg::REG_NONE;
        endcase
        return r;
    endfunction

    function automatic timer2_pkg::t2_mode_t mode_of(input timer2_pkg::timer2_control_t c);
        timer2_pkg::t2_mode_t m;
        if (!c.run_control) begin
            m = timer2_pkg::MODE_OFF;
        end else if (c.rx_clock_select || c.tx_clock_select) begin
            m = timer2_pkg::MODE_BAUD;
        end else if (c.capture_or_reload_select) begin
            m = timer2_pkg::MODE_CAPTURE;
        end else begin
            m = timer2_pkg::MODE_RELOAD;
        end
        return m;
    endfunction

    function automatic logic write_to(input logic en, input timer2_pkg::t2_reg_t sel,
                                      input timer2_pkg::t2_reg_t target);
        return en && (sel == target);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    timer2_pkg::timer2_control_t ctrl_q;
    timer2_pkg::t2_mode_t        mode;
    timer2_pkg::t2_reg_t         acc_reg;

    logic [15:0] count_q;
    logic [7:0]  cap_lo_q;
    logic [7:0]  cap_hi_q;
    logic [3:0]  presc_q;
    logic [3:0]  presc_top;
    logic        presc_tick;
    logic        count_fall;
    logic        trig_fall;
    logic        inc;
    logic        ovf;
    logic        trig;
    logic        wr_en;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    logic        rx_tick_q;
    logic        tx_tick_q;
    logic [7:0]  wbyte;
    logic [1:0]  pin_bus;
    logic [1:0]  fall_bus;
    logic        wr_ctrl;
    logic        wr_cnt_lo;
    logic        wr_cnt_hi;
    logic        wr_cap_lo;
    logic        wr_cap_hi;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    assign pin_bus = {external_trigger_pin, external_count_pin};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            falling_edge_sync u_sync (
                .clk  (clk),
                .rst  (rst),
                .pin  (pin_bus[i]),
                .fall (fall_bus[i])
            );
        end
    endgenerate

    assign count_fall = fall_bus[0];
    assign trig_fall  = fall_bus[1];

    // ----------------------------------------------------------------
    // oscillator prescaler
    // ----------------------------------------------------------------
    assign mode = mode_of(ctrl_q);

    always_comb begin
        if (mode == timer2_pkg::MODE_BAUD) begin
            presc_top = 4'(BAUD_DIV - 1);
        end else begin
            presc_top = 4'(TIMER_DIV - 1);
        end
    end

    assign presc_tick = (mode != timer2_pkg::MODE_OFF) && (presc_q >= presc_top);

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_q <= 4'h0;
        end else if (mode == timer2_pkg::MODE_OFF || presc_tick) begin
            // restarts from zero while stopped, so a start always sees a full period
            presc_q <= 4'h0;
        end else begin
            presc_q <= presc_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // count events
    // ----------------------------------------------------------------
    assign inc = (mode != timer2_pkg::MODE_OFF)
               && (ctrl_q.count_source_select ? count_fall : presc_tick);
    assign ovf = inc && (count_q == `T2_COUNT_MAX);
    assign trig = (mode != timer2_pkg::MODE_OFF)
                && ctrl_q.external_trigger_enable && trig_fall;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign acc_reg = reg_of(paddr);
    assign wr_en   = psel && penable && pready_q && pwrite && !pslverr_q;
    assign wbyte   = pwdata[7:0];

    // ----------------------------------------------------------------
    // write strobes
    // ----------------------------------------------------------------
    assign wr_ctrl   = write_to(wr_en, acc_reg, timer2_pkg::REG_CONTROL);
    assign wr_cnt_lo = write_to(wr_en, acc_reg, timer2_pkg::REG_COUNT_LO);
    assign wr_cnt_hi = write_to(wr_en, acc_reg, timer2_pkg::REG_COUNT_HI);
    assign wr_cap_lo = write_to(wr_en, acc_reg, timer2_pkg::REG_CAP_LO);
    assign wr_cap_hi = write_to(wr_en, acc_reg, timer2_pkg::REG_CAP_HI);

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (psel && !penable && !pready_q) begin
            // read data and error are latched in the setup cycle
            pready_q  <= 1'b1;
            pslverr_q <= (acc_reg == timer2_pkg::REG_NONE);
            unique case (acc_reg)
                timer2_pkg::REG_CONTROL:  prdata_q <= {24'h00_0000, ctrl_q};
                timer2_pkg::REG_COUNT_LO: prdata_q <= {24'h00_0000, count_q[7:0]};
                timer2_pkg::REG_COUNT_HI: prdata_q <= {24'h00_0000, count_q[15:8]};
                timer2_pkg::REG_CAP_LO:   prdata_q <= {24'h00_0000, cap_lo_q};
                timer2_pkg::REG_CAP_HI:   prdata_q <= {24'h00_0000, cap_hi_q};
                timer2_pkg::REG_NONE:     prdata_q <= 32'h0000_0000;
            endcase
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control register and flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `T2_CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wbyte;
            end
            // hardware set wins over a software clear in the same cycle
            if (ovf && mode != timer2_pkg::MODE_BAUD) begin
                ctrl_q.overflow_flag <= 1'b1;
            end
            if (trig) begin
                ctrl_q.external_event_flag <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= {`T2_BYTE_RESET, `T2_BYTE_RESET};
        end else if (wr_cnt_lo) begin
            // a software write beats a same-cycle increment or reload
            count_q[7:0] <= wbyte;
        end else if (wr_cnt_hi) begin
            count_q[15:8] <= wbyte;
        end else begin
            unique case (mode)
                timer2_pkg::MODE_OFF: begin
                    count_q <= count_q;
                end
                timer2_pkg::MODE_CAPTURE: begin
                    if (inc) begin
                        count_q <= count_q + 16'h0001;
                    end
                end
                timer2_pkg::MODE_RELOAD: begin
                    if (ovf || trig) begin
                        count_q <= {cap_hi_q, cap_lo_q};
                    end else if (inc) begin
                        count_q <= count_q + 16'h0001;
                    end
                end
                timer2_pkg::MODE_BAUD: begin
                    // a trigger edge only sets the flag here, never reloads
                    if (ovf) begin
                        count_q <= {cap_hi_q, cap_lo_q};
                    end else if (inc) begin
                        count_q <= count_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // capture registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_lo_q <= `T2_BYTE_RESET;
            cap_hi_q <= `T2_BYTE_RESET;
        end else if (trig && mode == timer2_pkg::MODE_CAPTURE) begin
            // a pin capture beats a same-cycle software write
            cap_lo_q <= count_q[7:0];
            cap_hi_q <= count_q[15:8];
        end else if (wr_cap_lo) begin
            cap_lo_q <= wbyte;
        end else if (wr_cap_hi) begin
            cap_hi_q <= wbyte;
        end
    end

    // ----------------------------------------------------------------
    // interrupt request and serial clock sources
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= timer2_irq_enable
                  && (ctrl_q.overflow_flag || ctrl_q.external_event_flag);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end else begin
            rx_tick_q <= ctrl_q.rx_clock_select ? ovf : timer1_overflow;
            tx_tick_q <= ctrl_q.tx_clock_select ? ovf : timer1_overflow;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign timer2_irq   = irq_q;
    assign rx_baud_tick = rx_tick_q;
    assign tx_baud_tick = tx_tick_q;

endmodule

`default_nettype wire

/* verif/timer2_props.sv */
// port-level assertions for the timer 2 unit
`timescale 1ns/1ps
`default_nettype none
module timer2_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer2_irq_enable,
    input wire logic        timer2_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_one_cycle; pready |=> !pready; endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("ready held too long");
    property p_ready_sel; pready |-> psel && penable; endproperty
    a_ready_sel: assert property (p_ready_sel) else $error("ready outside access");
    property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error without ready or zero data");
    property p_unmapped; psel && !penable && paddr > 12'h010 |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_irq_gate; timer2_irq |-> $past(timer2_irq_enable); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
    property p_irq_drop; !timer2_irq_enable ##1 !timer2_irq_enable |-> !timer2_irq; endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq stuck");
endmodule
bind timer2_capture_reload_unit timer2_props u_props (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer2_irq_enable(timer2_irq_enable), .timer2_irq(timer2_irq));
`default_nettype wire

/* verif/serial_port_model.sv */
// serial port side: makes timer 1 overflows and counts baud ticks
`timescale 1ns/1ps
`default_nettype none
module serial_port_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rx_baud_tick,
    input  wire logic tx_baud_tick,
    output var  logic timer1_overflow,
    output var  int   rx_cnt,
    output var  int   tx_cnt
);
    logic [2:0] div_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 3'h0;
            timer1_overflow <= 1'b0;
            rx_cnt <= 0;
            tx_cnt <= 0;
        end else begin
            div_q <= div_q + 3'h1;
            timer1_overflow <= (div_q == 3'h7);
            rx_cnt <= rx_cnt + int'(rx_baud_tick);
            tx_cnt <= tx_cnt + int'(tx_baud_tick);
        end
    end
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking testbench for the timer 2 unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cpin = 1, tpin = 1, ien = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, irq, rxt, txt, t1o, er;
    int          rx_cnt, tx_cnt, error_cnt = 0, samples_checked = 0;
    timer2_capture_reload_unit DUT (.clk(clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(cpin), .external_trigger_pin(tpin), .timer1_overflow(t1o),
        .timer2_irq_enable(ien), .timer2_irq(irq), .rx_baud_tick(rxt), .tx_baud_tick(txt));
    serial_port_model sp (.clk(clk), .rst(rst), .rx_baud_tick(rxt), .tx_baud_tick(txt),
        .timer1_overflow(t1o), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));
    initial begin
        forever #50 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // bus, compare and pin pulse tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int n, input bit trig);
        repeat (n) begin
            @(posedge clk);
            if (trig) tpin <= 1'b0; else cpin <= 1'b0;
            repeat (3) @(posedge clk);
            tpin <= 1'b1; cpin <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            apb(12'(4 * i), 1'b0, 8'h00);
            cmp(rd, 32'h0000_0000);
            cmp({31'h0, er}, {31'h0, i == 5});
        end
    endtask
    task automatic t_reload;
        apb(12'h00C, 1'b1, 8'h34); apb(12'h010, 1'b1, 8'h12); apb(12'h004, 1'b1, 8'hFE); apb(12'h008, 1'b1, 8'hFF);
        apb(12'h000, 1'b1, 8'h04);
        // two ticks of twelve cycles overflow the count into the reload value, flag comes from hardware only
        repeat (30) @(posedge clk);
        apb(12'h000, 1'b0, 8'h00); cmp(rd, 32'h0000_0084);
        apb(12'h008, 1'b0, 8'h00); cmp(rd, 32'h0000_0012);
        cmp({31'h0, irq}, 32'h1);
        apb(12'h000, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
    endtask
    task automatic t_capture;
        // counter source with a quiet count pin holds the count still
        apb(12'h010, 1'b1, 8'h77); apb(12'h004, 1'b1, 8'hCD); apb(12'h008, 1'b1, 8'hAB);
        apb(12'h000, 1'b1, 8'h0F);
        pulse(1, 1'b1);
        apb(12'h000, 1'b0, 8'h00); cmp(rd, 32'h0000_004F);
        apb(12'h00C, 1'b0, 8'h00); cmp(rd, 32'h0000_00CD);
        apb(12'h010, 1'b0, 8'h00); cmp(rd, 32'h0000_00AB);
        apb(12'h00C, 1'b1, 8'h11); apb(12'h010, 1'b1, 8'h22); apb(12'h000, 1'b1, 8'h0E);
        pulse(1, 1'b1);
        apb(12'h000, 1'b0, 8'h00); cmp(rd, 32'h0000_004E);
        apb(12'h008, 1'b0, 8'h00); cmp(rd, 32'h0000_0022);
        apb(12'h004, 1'b0, 8'h00); cmp(rd, 32'h0000_0011);
        apb(12'h000, 1'b1, 8'h00);
    endtask
    task automatic t_baud;
        int rx0;
        int tx0;
        apb(12'h004, 1'b1, 8'hFF); apb(12'h008, 1'b1, 8'hFF); apb(12'h00C, 1'b1, 8'hFF); apb(12'h010, 1'b1, 8'hFF);
        apb(12'h000, 1'b1, 8'h1C);
        pulse(1, 1'b1);
        // transmit wraps every second cycle, receive follows timer 1 every eighth
        rx0 = rx_cnt;
        tx0 = tx_cnt;
        repeat (24) @(posedge clk);
        cmp(32'(rx_cnt - rx0), 32'h0000_0003);
        cmp(32'(tx_cnt - tx0), 32'h0000_000C);
        apb(12'h000, 1'b0, 8'h00); cmp(rd, 32'h0000_005C);
        apb(12'h000, 1'b1, 8'h00);
    endtask
    task automatic t_counter;
        apb(12'h000, 1'b1, 8'h00); apb(12'h004, 1'b1, 8'h00); apb(12'h008, 1'b1, 8'h00);
        apb(12'h000, 1'b1, 8'h04);
        // stop lands 90 cycles after start: seven ticks of twelve
        repeat (87) @(posedge clk);
        apb(12'h000, 1'b1, 8'h00);
        apb(12'h004, 1'b0, 8'h00); cmp(rd, 32'h0000_0007);
        apb(12'h004, 1'b1, 8'h00);
        apb(12'h000, 1'b1, 8'h06);
        pulse(3, 1'b0);
        apb(12'h000, 1'b1, 8'h00);
        apb(12'h004, 1'b0, 8'h00); cmp(rd, 32'h0000_0003);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_reload;
        t_capture;
        t_baud;
        t_counter;
        print_verdict;
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
